// ===== hdl/dsf_pkg.sv
package dsf_pkg;
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int FALL_THRU_NS = 215;
  localparam int FALL_THRU_CYC = (FALL_THRU_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] FALL_THRU_LOAD = 3'(FALL_THRU_CYC - 1);
  localparam int SLICE_SPACE_AVAIL_LOW_NS = 42;
  localparam int SLICE_SPACE_AVAIL_LOW_CYC = (SLICE_SPACE_AVAIL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] SLICE_SPACE_AVAIL_LOW_LOAD = 2'(SLICE_SPACE_AVAIL_LOW_CYC);
  localparam int WOSC_PERIOD_NS = 320;
  localparam int WOSC_HALF_CYC = WOSC_PERIOD_NS / (2 * CLK_NS);
  localparam logic [2:0] WOSC_HALF_LAST = 3'(WOSC_HALF_CYC - 1);

  // FIFO geometry
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 20;
  localparam logic [4:0] FIFO_FULL_COUNT = 5'h10;
  localparam int FLAG_TIMING_ERR = 18;

  // Disk word framing
  localparam logic [7:0] SYNC_PATTERN = 8'h6e;
  localparam logic [3:0] WORD_LAST_BIT = 4'hf;
  localparam logic [2:0] OP_WRITE_DATA = 3'h3;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0c;
  localparam logic [7:0] DRV_OFS = 8'h10;
  localparam logic [7:0] DIRECT_OFS = 8'h14;

  // Control register fields
  localparam int CTRL_DIR_WRITE = 0;
  localparam int CTRL_DIRECT = 1;
  localparam int CTRL_OP_LSB = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Command register fields
  localparam int CMD_START = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_CLEAR = 2;

  // Status register fields
  localparam int STAT_STARTED = 0;
  localparam int STAT_READ = 1;
  localparam int STAT_SYNC = 2;
  localparam int STAT_WRITE = 3;
  localparam int STAT_SPACE = 4;
  localparam int STAT_WORD = 5;
  localparam int STAT_TIMERR = 6;
  localparam int STAT_START_REQ = 7;
  localparam int STAT_COUNT_LSB = 8;

  // Drive status word bit positions
  localparam int DRV_DRIVE_N_A = 15;
  localparam int DRV_NOT_READY = 14;
  localparam int DRV_WPROT = 13;
  localparam int DRV_WCHECK = 12;
  localparam int DRV_SEEK_INC = 10;
  localparam int DRV_JUMPER_B = 7;
  localparam int DRV_JUMPER_A = 6;
endpackage

// ===== hdl/dsf_top.sv
`timescale 1ns/1ps
module dsf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rd_clk_in,
  input wire logic rd_data_in,
  input wire logic int_reset_in,
  input wire logic drive_n_a,
  input wire logic drive_not_ready_n,
  input wire logic write_protect_n,
  input wire logic write_check_n,
  input wire logic seek_incomplete_n,
  input wire logic reverse_jumper_a_n,
  input wire logic reverse_jumper_b_n,
  input wire logic [4:0] sector_addr_n,
  output logic wr_clk_out,
  output logic wr_data_out,
  output logic crc_check_en
);

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == dsf_pkg::CTRL_OFS) || (a == dsf_pkg::CMD_OFS) ||
      (a == dsf_pkg::STAT_OFS) || (a == dsf_pkg::DATA_OFS) ||
      (a == dsf_pkg::DRV_OFS) || (a == dsf_pkg::DIRECT_OFS);
  endfunction

  function automatic logic all_ready(input logic [3:0] s);
    all_ready = &s;
  endfunction

  // Pin synchronisers
  logic [1:0] rd_clk_s;
  logic [1:0] rd_dat_s;
  logic [1:0] irst_s;
  logic [11:0] drv_s1;
  logic [11:0] drv_s2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_clk_s <= 2'h0;
      rd_dat_s <= 2'h0;
      irst_s <= 2'h0;
      drv_s1 <= 12'hfff;
      drv_s2 <= 12'hfff;
    end
    else
    begin
      rd_clk_s <= {rd_clk_s[0], rd_clk_in};
      rd_dat_s <= {rd_dat_s[0], rd_data_in};
      irst_s <= {irst_s[0], int_reset_in};
      drv_s1 <= {drive_n_a, drive_not_ready_n, write_protect_n, write_check_n,
        seek_incomplete_n, reverse_jumper_b_n, reverse_jumper_a_n, sector_addr_n};
      drv_s2 <= drv_s1;
    end
  end

  // APB access decode
  logic apb_wr;
  logic apb_rd;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~reg_mapped(paddr);

  logic [7:0] ctrl;
  logic xfer_dir_write;
  logic direct_mode_n;
  logic [2:0] operation_register;
  assign xfer_dir_write = ctrl[dsf_pkg::CTRL_DIR_WRITE];
  assign direct_mode_n = ~ctrl[dsf_pkg::CTRL_DIRECT];
  assign operation_register = ctrl[dsf_pkg::CTRL_OP_LSB +: 3];
  logic op_is_write_data;
  assign op_is_write_data = operation_register == dsf_pkg::OP_WRITE_DATA;

  // Direction is software-held, so a write-data op does not read the header first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= dsf_pkg::CTRL_RESET;
    else if (apb_wr && paddr == dsf_pkg::CTRL_OFS)
      ctrl <= pwdata[7:0];
  end

  logic cmd_wr;
  logic start_xfer_pulse_n;
  logic xfer_abort_n;
  logic controller_clear_n;
  logic xfer_logic_reset_n;
  assign cmd_wr = apb_wr && paddr == dsf_pkg::CMD_OFS;
  assign start_xfer_pulse_n = ~(cmd_wr & pwdata[dsf_pkg::CMD_START]);
  assign xfer_abort_n = ~(cmd_wr & pwdata[dsf_pkg::CMD_ABORT]);
  assign controller_clear_n = ~(cmd_wr & pwdata[dsf_pkg::CMD_CLEAR]);
  assign xfer_logic_reset_n = xfer_abort_n & controller_clear_n & ~irst_s[1];

  // Write oscillator
  logic [2:0] wosc_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wosc_cnt <= 3'h0;
      wr_clk_out <= 1'b0;
    end
    else if (wosc_cnt == dsf_pkg::WOSC_HALF_LAST)
    begin
      wosc_cnt <= 3'h0;
      wr_clk_out <= ~wr_clk_out;
    end
    else
      wosc_cnt <= wosc_cnt + 3'h1;
  end

  // Disk bit clock and its leading edge
  logic disk_bit_clock_n;
  logic disk_bit_clock_n_n_q;
  logic dtick;
  assign disk_bit_clock_n = xfer_dir_write ? ~wr_clk_out : ~rd_clk_s[1];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disk_bit_clock_n_n_q <= 1'b1;
    else
      disk_bit_clock_n_n_q <= disk_bit_clock_n;
  end
  assign dtick = disk_bit_clock_n_n_q & ~disk_bit_clock_n;

  // Transfer control flops
  logic start_request;
  logic xfer_started;
  logic write_active;
  logic sync_found;
  logic read_active;
  logic read_active_n;
  logic sync_pattern_seen_n;
  assign read_active_n = ~read_active;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_request <= 1'b0;
      xfer_started <= 1'b0;
      write_active <= 1'b0;
      sync_found <= 1'b0;
      read_active <= 1'b0;
    end
    else if (!xfer_logic_reset_n)
    begin
      start_request <= 1'b0;
      xfer_started <= 1'b0;
      write_active <= 1'b0;
      sync_found <= 1'b0;
      read_active <= 1'b0;
    end
    else
    begin
      if (!start_xfer_pulse_n)
        start_request <= 1'b1;
      if (dtick)
      begin
        xfer_started <= start_request;
        if (start_request && xfer_started && xfer_dir_write)
          write_active <= 1'b1;
        if (xfer_started && !xfer_dir_write && !sync_pattern_seen_n)
          sync_found <= 1'b1;
        if (sync_found && !xfer_dir_write)
          read_active <= 1'b1;
      end
    end
  end
  assign crc_check_en = sync_found;

  // Bit counter
  logic [3:0] bit_cnt;
  logic bit_counter_clear_n;
  logic word_boundary;
  assign bit_counter_clear_n = write_active | ~read_active_n;
  assign word_boundary = bit_cnt == dsf_pkg::WORD_LAST_BIT;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_cnt <= 4'h0;
    else if (!bit_counter_clear_n)
      bit_cnt <= 4'h0;
    else if (dtick)
      bit_cnt <= bit_cnt + 4'h1;
  end

  // Read deserialiser and sync detect
  logic [15:0] des;
  logic [15:0] next_des;
  logic disk_push;
  assign next_des = {des[14:0], rd_dat_s[1]};
  assign sync_pattern_seen_n = ~(des[7:0] == dsf_pkg::SYNC_PATTERN);
  assign disk_push = dtick & read_active & word_boundary;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      des <= 16'h0000;
    else if (dtick && xfer_started && !xfer_dir_write)
      des <= next_des;
  end

  // FIFO state
  logic [dsf_pkg::FIFO_WIDTH-1:0] mem [dsf_pkg::FIFO_DEPTH];
  logic [3:0] wp;
  logic [3:0] rp;
  logic [4:0] count;
  logic [2:0] ft_cnt;
  logic [1:0] space_hold;
  logic pop_hold;
  logic [3:0] slice_space_avail;
  logic [3:0] slice_word_avail;
  logic fifo_space_avail_n;
  logic fifo_word_avail_n;
  assign slice_space_avail = {4{count != dsf_pkg::FIFO_FULL_COUNT && space_hold == 2'h0}};
  assign slice_word_avail = {4{count != 5'h00 && ft_cnt == 3'h0 && !pop_hold}};
  assign fifo_space_avail_n = ~all_ready(slice_space_avail);
  assign fifo_word_avail_n = ~all_ready(slice_word_avail);

  // Serialiser
  logic serialiser_load_n;
  logic [15:0] ser;
  assign serialiser_load_n = ~(dtick & xfer_dir_write &
    ((start_request & ~xfer_started) | (write_active & word_boundary)));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser <= 16'h0000;
      wr_data_out <= 1'b0;
    end
    else
    begin
      // Load tick still sends the last bit of the old word
      if (dtick && write_active)
        wr_data_out <= ser[15];
      if (!serialiser_load_n)
        ser <= fifo_word_avail_n ? 16'h0000 : mem[rp][15:0];
      else if (dtick && write_active)
        ser <= {ser[14:0], 1'b0};
    end
  end

  // Push and pop sources by direction
  logic apb_data_wr;
  logic apb_data_rd;
  logic push_req;
  logic pop_req;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_timing_error;
  logic [dsf_pkg::FIFO_WIDTH-1:0] fifo_in_bits;
  assign apb_data_wr = apb_wr && paddr == dsf_pkg::DATA_OFS;
  assign apb_data_rd = apb_rd && paddr == dsf_pkg::DATA_OFS;
  assign push_req = xfer_dir_write ? apb_data_wr : disk_push;
  assign pop_req = xfer_dir_write ? ~serialiser_load_n : apb_data_rd;
  assign fifo_push = push_req & direct_mode_n & ~fifo_space_avail_n;
  assign fifo_pop = pop_req & ~fifo_word_avail_n;
  assign fifo_in_bits = xfer_dir_write ? pwdata[dsf_pkg::FIFO_WIDTH-1:0] :
    {1'b0, fifo_timing_error, 2'b00, next_des};

  always_ff @(posedge pclk)
  begin
    if (fifo_push)
      mem[wp] <= fifo_in_bits;
  end

  // Clear resets pointers, count and flag timers; storage keeps stale words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
      ft_cnt <= 3'h0;
      space_hold <= 2'h0;
      pop_hold <= 1'b0;
    end
    else if (!controller_clear_n)
    begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
      ft_cnt <= 3'h0;
      space_hold <= 2'h0;
      pop_hold <= 1'b0;
    end
    else
    begin
      if (fifo_push)
        wp <= wp + 4'h1;
      if (fifo_pop)
        rp <= rp + 4'h1;
      count <= count + {4'h0, fifo_push} - {4'h0, fifo_pop};
      pop_hold <= fifo_pop;
      if (fifo_push)
        space_hold <= dsf_pkg::SLICE_SPACE_AVAIL_LOW_LOAD - 2'h1;
      else if (space_hold != 2'h0)
        space_hold <= space_hold - 2'h1;
      if (fifo_push && count == 5'h00)
        ft_cnt <= dsf_pkg::FALL_THRU_LOAD;
      else if (ft_cnt != 3'h0)
        ft_cnt <= ft_cnt - 3'h1;
    end
  end

  // Timing error; a set in the clearing cycle wins
  logic terr_set;
  assign terr_set = (!xfer_dir_write && push_req && fifo_space_avail_n) ||
    (xfer_dir_write && !serialiser_load_n && fifo_word_avail_n);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fifo_timing_error <= 1'b0;
    else if (terr_set)
      fifo_timing_error <= 1'b1;
    else if (!xfer_logic_reset_n)
      fifo_timing_error <= 1'b0;
  end

  // Direct read register follows every disk word, whatever the mode
  logic [15:0] direct_word;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      direct_word <= 16'h0000;
    else if (disk_push)
      direct_word <= next_des;
  end

  // Disk-side status into software view
  logic [2:0] st_s1;
  logic [2:0] st_s2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_s1 <= 3'h0;
      st_s2 <= 3'h0;
    end
    else
    begin
      st_s1 <= {sync_found, ~read_active_n, xfer_started};
      st_s2 <= st_s1;
    end
  end

  logic [31:0] stat_word;
  logic [31:0] drv_word;
  always_comb
  begin
    stat_word = 32'h0;
    stat_word[dsf_pkg::STAT_STARTED] = st_s2[0];
    stat_word[dsf_pkg::STAT_READ] = st_s2[1];
    stat_word[dsf_pkg::STAT_SYNC] = st_s2[2];
    stat_word[dsf_pkg::STAT_WRITE] = write_active;
    stat_word[dsf_pkg::STAT_SPACE] = ~fifo_space_avail_n;
    stat_word[dsf_pkg::STAT_WORD] = ~fifo_word_avail_n;
    stat_word[dsf_pkg::STAT_TIMERR] = fifo_timing_error;
    stat_word[dsf_pkg::STAT_START_REQ] = start_request;
    stat_word[dsf_pkg::STAT_COUNT_LSB +: 5] = count;
    drv_word = 32'h0;
    drv_word[dsf_pkg::DRV_DRIVE_N_A] = ~drv_s2[11];
    drv_word[dsf_pkg::DRV_NOT_READY] = ~drv_s2[10];
    drv_word[dsf_pkg::DRV_WPROT] = ~drv_s2[9];
    drv_word[dsf_pkg::DRV_WCHECK] = ~drv_s2[8];
    drv_word[dsf_pkg::DRV_SEEK_INC] = ~drv_s2[7];
    drv_word[dsf_pkg::DRV_JUMPER_B] = ~drv_s2[6];
    drv_word[dsf_pkg::DRV_JUMPER_A] = ~drv_s2[5];
    drv_word[4:0] = ~drv_s2[4:0];
  end

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        dsf_pkg::CTRL_OFS: prdata <= {24'h0, ctrl};
        dsf_pkg::STAT_OFS: prdata <= stat_word;
        dsf_pkg::DATA_OFS: prdata <= {12'h0, mem[rp]};
        dsf_pkg::DRV_OFS: prdata <= drv_word;
        dsf_pkg::DIRECT_OFS: prdata <= {16'h0, direct_word};
        default: prdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start_cmd;
    !start_xfer_pulse_n && xfer_logic_reset_n;
  endsequence
  sequence s_first_tick;
    start_request && !xfer_started && dtick && xfer_logic_reset_n;
  endsequence

  a_start_req_set: assert property (s_start_cmd |=> start_request)
    else $error("start request not set by start command");
  a_started_on_tick: assert property (s_first_tick |=> xfer_started)
    else $error("transfer not started on first disk tick");
  a_started_only_tick: assert property ($rose(xfer_started) |->
    $past(dtick) && $past(start_request))
    else $error("transfer started without a disk tick");
  a_write_second: assert property ($rose(write_active) |->
    $past(xfer_started) && $past(dtick))
    else $error("write flop set before second tick");
  a_counter_held: assert property (!write_active && !read_active |=> bit_cnt == 4'h0)
    else $error("bit counter runs while cleared");
  a_sync_detect: assert property (xfer_logic_reset_n && dtick && xfer_started && !xfer_dir_write &&
    des[7:0] == 8'h6e |=> sync_found)
    else $error("sync pattern missed");
  a_read_after_sync: assert property ($rose(read_active) |-> $past(sync_found))
    else $error("read flop set without sync");
  a_logic_reset: assert property (!xfer_logic_reset_n |=>
    !start_request && !xfer_started && !write_active && !read_active)
    else $error("transfer logic not reset");
  a_direct_blocks: assert property (push_req && !direct_mode_n |-> !fifo_push)
    else $error("push accepted in direct mode");
  a_space_dip: assert property (fifo_push |=> fifo_space_avail_n)
    else $error("space available did not drop on push");
  a_full_space: assert property (count == 5'h10 |-> fifo_space_avail_n)
    else $error("space reported while full");
  a_fall_through: assert property (disable iff (!presetn || !controller_clear_n)
    fifo_push && count == 5'h00 && !fifo_pop |=>
    fifo_word_avail_n [*5] ##1 !fifo_word_avail_n)
    else $error("fall-through latency wrong");
  a_pop_low: assert property (fifo_pop |=> fifo_word_avail_n)
    else $error("word available during pop");
  a_clear_ctrl: assert property (!controller_clear_n |=> count == 5'h00 && fifo_word_avail_n)
    else $error("clear left FIFO control state");
  a_timing_err: assert property (terr_set |=> fifo_timing_error)
    else $error("timing error not flagged");
endmodule

// ===== tb/dsf_drive_model.sv
`timescale 1ns/1ps
module dsf_drive_model (
  input wire logic wr_clk_out,
  input wire logic wr_data_out,
  output logic rd_clk_in,
  output logic rd_data_in,
  output logic [63:0] wr_hist
);
  initial
  begin
    rd_clk_in = 1'b0;
    rd_data_in = 1'b0;
    wr_hist = '0;
  end

  // Capture write data mid-cell, away from the tick
  always @(negedge wr_clk_out)
  begin
    wr_hist <= {wr_hist[62:0], wr_data_out};
  end

  // Read clock runs only inside a frame, data valid around rising edge
  task automatic send(input logic [15:0] w, input int n);
    #13;
    for (int i = 15; i >= 16 - n; i--)
    begin
      rd_data_in = w[i];
      #160;
      rd_clk_in = 1'b1;
      #160;
      rd_clk_in = 1'b0;
    end
    // Released line must not keep the last bit
    rd_data_in = ~rd_data_in;
  endtask
endmodule

// ===== tb/disk_serial_transfer_fifo_bench.sv
`timescale 1ns/1ps
module disk_serial_transfer_fifo_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic rd_clk_in, rd_data_in, int_reset_in, wr_clk_out, wr_data_out, crc_check_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] pins;
  logic [63:0] wr_hist;
  logic [19:0] wq [16];
  int error_cnt, samples_checked, seed;

  dsf_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rd_clk_in(rd_clk_in), .rd_data_in(rd_data_in), .int_reset_in(int_reset_in),
    .drive_n_a(pins[11]), .drive_not_ready_n(pins[10]), .write_protect_n(pins[9]),
    .write_check_n(pins[8]), .seek_incomplete_n(pins[7]), .reverse_jumper_b_n(pins[6]),
    .reverse_jumper_a_n(pins[5]), .sector_addr_n(pins[4:0]), .wr_clk_out(wr_clk_out),
    .wr_data_out(wr_data_out), .crc_check_en(crc_check_en)
  );

  dsf_drive_model dm_u (
    .wr_clk_out(wr_clk_out), .wr_data_out(wr_data_out), .rd_clk_in(rd_clk_in),
    .rd_data_in(rd_data_in), .wr_hist(wr_hist)
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #1000000;
    error_cnt++;
    complete_run();
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic stat();
    apb(1'b0, dsf_pkg::STAT_OFS, 32'h0);
  endtask

  function automatic logic [31:0] drv_exp(input logic [11:0] p);
    logic [31:0] e;
    e = '0;
    e[dsf_pkg::DRV_DRIVE_N_A] = ~p[11];
    e[dsf_pkg::DRV_NOT_READY] = ~p[10];
    e[dsf_pkg::DRV_WPROT] = ~p[9];
    e[dsf_pkg::DRV_WCHECK] = ~p[8];
    e[dsf_pkg::DRV_SEEK_INC] = ~p[7];
    e[dsf_pkg::DRV_JUMPER_B] = ~p[6];
    e[dsf_pkg::DRV_JUMPER_A] = ~p[5];
    e[4:0] = ~p[4:0];
    return e;
  endfunction

  function automatic logic [31:0] seen(input logic [63:0] h, input logic [15:0] w);
    seen = 32'h0;
    for (int i = 0; i <= 48; i++)
      if (h[i +: 16] === w)
        seen = 32'h1;
  endfunction

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_reset_in = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    seed = $urandom(32'hf45c);
    pins = 12'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dsf_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_reset", {24'h0, dsf_pkg::CTRL_RESET}, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, serr});
    chk("unmapped_data", 32'h0, rd);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      pins <= 12'($urandom);
      repeat (3) @(posedge pclk);
      apb(1'b0, dsf_pkg::DRV_OFS, 32'h0);
      chk("drive_status", drv_exp(pins), rd);
    end
    apb(1'b1, dsf_pkg::CTRL_OFS, 32'h1);
    for (int i = 0; i < 17; i++)
    begin
      if (i < 16)
        wq[i] = 20'($urandom);
      apb(1'b1, dsf_pkg::DATA_OFS, {12'h0, wq[i % 16]});
      stat();
      if (i == 0)
        chk("word_early", 32'h0, {31'h0, rd[dsf_pkg::STAT_WORD]});
      chk("count", 32'((i < 16) ? i + 1 : 16), {27'h0, rd[12:8]});
    end
    repeat (8) @(posedge pclk);
    stat();
    chk("full_flags", 32'h20, {24'h0, rd[7:0]} & 32'h30);
    apb(1'b1, dsf_pkg::CTRL_OFS, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      repeat (8) @(posedge pclk);
      if (i == 8)
      begin
        stat();
        chk("word_mid", 32'h30, {24'h0, rd[7:0]} & 32'h30);
      end
      apb(1'b0, dsf_pkg::DATA_OFS, 32'h0);
      chk("fifo_data", {12'h0, wq[i]}, rd);
    end
    repeat (8) @(posedge pclk);
    stat();
    chk("empty", 32'h10, rd & 32'h1f30);
    apb(1'b1, dsf_pkg::CTRL_OFS, 32'h3);
    apb(1'b1, dsf_pkg::DATA_OFS, 32'h5);
    apb(1'b1, dsf_pkg::CTRL_OFS, 32'h1);
    stat();
    chk("direct_push", 32'h0, {27'h0, rd[12:8]});
    apb(1'b1, dsf_pkg::DATA_OFS, 32'ha);
    apb(1'b1, dsf_pkg::DATA_OFS, 32'hb);
    apb(1'b1, dsf_pkg::CMD_OFS, 32'h1 << dsf_pkg::CMD_CLEAR);
    repeat (8) @(posedge pclk);
    stat();
    chk("clear", 32'h0, rd & 32'h1f20);
    apb(1'b1, dsf_pkg::DATA_OFS, {12'h0, wq[3]});
    repeat (8) @(posedge pclk);
    apb(1'b1, dsf_pkg::CTRL_OFS, 32'h0);
    apb(1'b0, dsf_pkg::DATA_OFS, 32'h0);
    chk("after_clear", {12'h0, wq[3]}, rd);
    apb(1'b1, dsf_pkg::CTRL_OFS, {24'h0, dsf_pkg::OP_WRITE_DATA, 5'h0});
    apb(1'b0, dsf_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_op", 32'h60, rd);
    apb(1'b1, dsf_pkg::CTRL_OFS, {24'h0, dsf_pkg::OP_WRITE_DATA, 5'h1});
    for (int i = 0; i < 2; i++)
    begin
      wq[i] = {4'h0, 16'($urandom)};
      apb(1'b1, dsf_pkg::DATA_OFS, {12'h0, wq[i]});
    end
    apb(1'b1, dsf_pkg::CMD_OFS, 32'h1 << dsf_pkg::CMD_START);
    stat();
    chk("start_req", 32'h1, {31'h0, rd[dsf_pkg::STAT_START_REQ]});
    repeat (400) @(posedge pclk);
    stat();
    chk("write_run", 32'hc9, rd & 32'h1fcf);
    chk("wr_word0", 32'h1, seen(wr_hist, wq[0][15:0]));
    chk("wr_word1", 32'h1, seen(wr_hist, wq[1][15:0]));
    apb(1'b1, dsf_pkg::CMD_OFS, 32'h1 << dsf_pkg::CMD_ABORT);
    repeat (4) @(posedge pclk);
    stat();
    chk("abort", 32'h10, rd & 32'h1fff);
    apb(1'b1, dsf_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, dsf_pkg::CMD_OFS, 32'h1 << dsf_pkg::CMD_START);
    dm_u.send(16'h0, 16);
    dm_u.send(16'h6e00, 8);
    for (int i = 0; i < 3; i++)
      dm_u.send(16'hffff, 16);
    repeat (8) @(posedge pclk);
    stat();
    chk("read_run", 32'hb7, {24'h0, rd[7:0]});
    chk("crc_en", 32'h1, {31'h0, crc_check_en});
    apb(1'b0, dsf_pkg::DATA_OFS, 32'h0);
    chk("read_word", 32'hffff, rd);
    apb(1'b0, dsf_pkg::DIRECT_OFS, 32'h0);
    chk("direct_word", 32'hffff, rd);
    for (int i = 0; i < 18; i++)
      dm_u.send(16'hffff, 16);
    repeat (8) @(posedge pclk);
    stat();
    chk("overflow", 32'h10e7, rd & 32'h1fff);
    @(posedge pclk);
    int_reset_in <= 1'b1;
    repeat (6) @(posedge pclk);
    int_reset_in <= 1'b0;
    repeat (6) @(posedge pclk);
    stat();
    chk("int_reset", 32'h1020, rd & 32'h1fff);
    chk("crc_off", 32'h0, {31'h0, crc_check_en});
    complete_run();
  end
endmodule
